// ---- hw/eam_monitor.sv ----
// Exclusive access monitor: load-exclusive tagging and store-exclusive gating.
`timescale 1ns/10ps
`default_nettype none
`include "eam_defines.svh"

// Behaviour
// - Little-endian lanes, byte 0 lowest address
// - Load-exclusive returns data, sets local tag
// - Tagged store-exclusive writes, status 0
// - Untagged store-exclusive suppressed, status 1
// - Word, halfword and byte sizes supported
// - Clear-exclusive removes local tag
// - Every store-exclusive removes local tag
// - Exception entry removes local tag
// - System keeps global tags per processor
// - Clear-exclusive leaves global tags alone
// - Store or exception clears global tags
// - Never stalls; failure only via status
module eam_monitor (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Request from the load/store pipeline
    input  wire logic        req_valid,
    input  wire logic [1:0]  req_op,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    input  wire logic [31:0] req_wdata,
    input  wire logic        exception_entry,
    // Answer to the pipeline
    output logic             rsp_valid,
    output logic [31:0]      rsp_data,
    output logic             rsp_status,
    output logic             local_tag,
    // Memory side
    input  wire logic [31:0] mem_rdata,
    output logic             mem_we,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic [3:0]       mem_be,
    output logic             global_tag_clear
);
    eam_pkg::eam_state_s s_q;
    eam_pkg::eam_state_s s_d;

    logic [4:0]  lane_shift;
    logic [3:0]  lane_be;
    logic [31:0] lane_mask;

    // Byte lanes follow the low address bits; lane 0 holds the least significant byte.
    always_comb begin
        lane_shift = {req_addr[1:0], 3'h0};
        case (req_size)
            `EAM_SIZE_BYTE: begin
                lane_be   = 4'h1 << req_addr[1:0];
                lane_mask = 32'h000000ff;
            end
            `EAM_SIZE_HALF: begin
                lane_be   = 4'h3 << {req_addr[1], 1'h0};
                lane_mask = 32'h0000ffff;
            end
            default: begin
                lane_be   = 4'hf;
                lane_mask = 32'hffffffff;
            end
        endcase
    end

    always_comb begin
        s_d           = s_q;
        s_d.rsp_valid = 1'h0;
        s_d.mem_we    = 1'h0;
        s_d.gclr      = 1'h0;
        // Every request is answered in the next cycle; nothing waits for exclusivity.
        if (req_valid) begin
            s_d.rsp_valid = 1'h1;
            s_d.mem_addr  = req_addr;
            case (eam_pkg::eam_op_e'(req_op))
                eam_pkg::EAM_OP_LOAD: begin
                    s_d.rsp_data   = (mem_rdata >> lane_shift) & lane_mask;
                    s_d.rsp_status = `EAM_STATUS_OK;
                    s_d.tag        = 1'h1;
                    s_d.tag_addr   = req_addr;
                    s_d.tag_size   = req_size;
                end
                eam_pkg::EAM_OP_STORE: begin
                    s_d.rsp_data  = 32'h00000000;
                    s_d.mem_wdata = (req_wdata & lane_mask) << lane_shift;
                    s_d.mem_be    = lane_be;
                    if (s_q.tag) begin
                        s_d.mem_we     = 1'h1;
                        s_d.rsp_status = `EAM_STATUS_OK;
                    end else begin
                        s_d.rsp_status = `EAM_STATUS_FAIL;
                    end
                    s_d.tag  = 1'h0;
                    s_d.gclr = 1'h1;
                end
                eam_pkg::EAM_OP_CLEAR: begin
                    // Only the local tag goes; global tags stay with the system.
                    s_d.tag        = 1'h0;
                    s_d.rsp_status = `EAM_STATUS_OK;
                end
                default: begin
                    s_d.rsp_status = `EAM_STATUS_OK;
                end
            endcase
        end
        // Exception wins over a load in the same cycle, so an interrupted sequence always fails.
        if (exception_entry) begin
            s_d.tag  = 1'h0;
            s_d.gclr = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q            <= '0;
            s_q.tag        <= `EAM_TAG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp_valid        = s_q.rsp_valid;
    assign rsp_data         = s_q.rsp_data;
    assign rsp_status       = s_q.rsp_status;
    assign local_tag        = s_q.tag;
    assign mem_we           = s_q.mem_we;
    assign mem_addr         = s_q.mem_addr;
    assign mem_wdata        = s_q.mem_wdata;
    assign mem_be           = s_q.mem_be;
    assign global_tag_clear = s_q.gclr;
endmodule
`default_nettype wire

// ---- hw/eam_defines.svh ----
// Constants of the exclusive access monitor.
`ifndef EAM_DEFINES_SVH
`define EAM_DEFINES_SVH
`define EAM_STATUS_OK      1'h0
`define EAM_STATUS_FAIL    1'h1
`define EAM_TAG_RESET      1'h0
`define EAM_SIZE_BYTE      2'h0
`define EAM_SIZE_HALF      2'h1
`define EAM_SIZE_WORD      2'h2
`define EAM_LANE_WIDTH     8
`endif

// ---- hw/eam_pkg.sv ----
// Types of the exclusive access monitor.
package eam_pkg;
    typedef enum logic [1:0] {
        EAM_OP_NONE  = 2'h0,
        EAM_OP_LOAD  = 2'h1,
        EAM_OP_STORE = 2'h3,
        EAM_OP_CLEAR = 2'h2
    } eam_op_e;

    typedef struct packed {
        logic        tag;
        logic [31:0] tag_addr;
        logic [1:0]  tag_size;
        logic        rsp_valid;
        logic [31:0] rsp_data;
        logic        rsp_status;
        logic        mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic [3:0]  mem_be;
        logic        gclr;
    } eam_state_s;
endpackage

// ---- tb/eam_monitor_asserts.sv ----
// Checker of the exclusive access monitor.
`timescale 1ns/10ps
`default_nettype none
module eam_chk (input wire logic clk_sys, reset_n, req_valid, exception_entry, rsp_valid, rsp_status, local_tag,
    input wire logic mem_we, global_tag_clear, input wire logic [1:0] req_op);
    wire ld = req_valid && req_op == 2'h1, st = req_valid && req_op == 2'h3, ex = exception_entry;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    property p_ld; ld && !ex |=> local_tag; endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_ok; st && local_tag && !ex |=> mem_we && !rsp_status; endproperty
    a_ok: assert property (p_ok) else $error("store");
    property p_no; st && !local_tag |=> !mem_we && rsp_status; endproperty
    a_no: assert property (p_no) else $error("refuse");
    property p_cl; req_valid && req_op == 2'h2 && !ex |=> !local_tag && !global_tag_clear; endproperty
    a_cl: assert property (p_cl) else $error("clear");
    property p_st; st |=> !local_tag && global_tag_clear; endproperty
    a_st: assert property (p_st) else $error("untag");
    property p_ex; ex |=> !local_tag && global_tag_clear; endproperty
    a_ex: assert property (p_ex) else $error("exception");
    property p_rv; req_valid |=> rsp_valid; endproperty
    a_rv: assert property (p_rv) else $error("answer");
    property p_rs; $rose(reset_n) |-> !local_tag; endproperty
    a_rs: assert property (p_rs) else $error("reset");
    cover property (st && local_tag);
    cover property (st && !local_tag);
    cover property (ld && ex);
endmodule
bind eam_monitor eam_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid),
    .exception_entry(exception_entry), .rsp_valid(rsp_valid), .rsp_status(rsp_status), .local_tag(local_tag),
    .mem_we(mem_we), .global_tag_clear(global_tag_clear), .req_op(req_op));
`default_nettype wire

// ---- tb/eam_mem_model.sv ----
// Word memory standing behind the monitor.
`timescale 1ns/10ps
`default_nettype none
module eam_mem (input wire logic clk_sys, mem_we, input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata, output logic [31:0] mem_rdata = 32'h0);
    always @(posedge clk_sys)
        for (int b = 0; b < 4; b++) if (mem_we && mem_be[b]) mem_rdata[8*b +: 8] <= mem_wdata[8*b +: 8];
endmodule
`default_nettype wire

// ---- tb/eam_testbench.sv ----
// Bench of the exclusive access monitor.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_sys = 1'h0, reset_n = 1'h0, req_valid = 1'h0, exception_entry = 1'h0;
    logic [1:0] req_op = 2'h0, req_size = 2'h0, o, s;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, w = 32'h0;
    wire rsp_valid, rsp_status, local_tag, mem_we, global_tag_clear;
    wire [3:0] mem_be;
    wire [31:0] mem_rdata, mem_addr, mem_wdata, rsp_data;
    logic [31:0] last = 32'h0;
    int err_total = 0, checks_done = 0, t = 0;
    always #2 clk_sys = ~clk_sys;
    eam_monitor u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .req_valid(req_valid), .req_op(req_op),
        .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata), .exception_entry(exception_entry),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_status(rsp_status), .local_tag(local_tag),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_be(mem_be), .global_tag_clear(global_tag_clear));
    eam_mem u_mem (.clk_sys(clk_sys), .mem_we(mem_we), .mem_be(mem_be), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(logic [36:0] e, g);
        checks_done++;
        err_total += int'(g !== e);
        if (g !== e) $display("wrong value response expected %h seen %h", e, g);
    endtask
    // The address changes with every request and only the tag decides success, so a load of any size arms any store.
    task automatic op(logic [31:0] a, d, logic x);
        logic [31:0] r;
        // A clear leaves the last answer data standing; a store answers zero.
        r = !o[1] ? w >> 8 * a[1:0] & ~(32'hffffffff << (8 << s)) : (&o ? 32'h0 : last);
        last = r;
        for (int b = 0; b < 4; b++)
            if (&o && t && b >> s == a[1:0] >> s) w[8*b +: 8] = 8'(d >> 8 * (b - a[1:0]));
        @(posedge clk_sys);
        {req_valid, req_op, req_size, req_addr, req_wdata, exception_entry} <= {1'h1, o, s, a, d, x};
        @(posedge clk_sys);
        {req_valid, exception_entry} <= 2'h0;
        #1;
        chk({1'h1, &o && !t, &o && t, &o || x, !o[1] && !x, r},
            {rsp_valid, rsp_status, mem_we, global_tag_clear, local_tag, rsp_data});
        t = !o[1] && !x;
    endtask
    initial begin
        void'($urandom(32'h5d99df75));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'h1;
        {o, s} = 4'he;
        op(32'h0, 32'h5, 1'h0);
        repeat (600) begin
            s = 2'($urandom_range(2));
            o = 2'($urandom_range(3, 1));
            op($urandom << s, $urandom, !o[1] && $urandom_range(3) == 0);
        end
        final_report();
    end
endmodule
`default_nettype wire
